// ### design/ascs_top.sv
// Startup configuration sequencer with Avalon-MM register slave
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ascs_top
    import ascs_pkg::*;
#(
    parameter int unsigned SRST_WAIT = SRST_CYCLES,
    parameter int unsigned CAL_LEN = CAL_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic single_ended_sync_input_n,
    input wire logic timestamp_sync_n,
    output logic serial_link_enable,
    output logic link_running,
    output logic link_data_phase,
    output logic cal_running,
    output logic cal_busy,
    output logic [MODE_W-1:0] link_mode_select,
    output logic [KM_W-1:0] multiframe_length_minus_one
);
    // Both counters are 16 bits wide
    if (SRST_WAIT < 1 || SRST_WAIT > 65535 || CAL_LEN < 1 ||
            CAL_LEN > 65535) begin : g_bad_count
        $error("ascs_top: bad count parameter");
    end

    logic sync_se_n;
    logic sync_ts_n;
    ascs_sync2 u_sync_se (.mclk(mclk), .rstn(rstn),
        .din(single_ended_sync_input_n), .dout(sync_se_n));
    ascs_sync2 u_sync_ts (.mclk(mclk), .rstn(rstn),
        .din(timestamp_sync_n), .dout(sync_ts_n));

    // Register state
    logic link_en, cal_en, trig, sync_sel, srst_busy;
    logic cal_bg, cal_ofs, overrange_enable;
    logic [OVR_THR_W-1:0] ovr_thr;
    logic [15:0] srst_cnt;
    logic ack;
    logic next_link_en, next_cal_en, next_trig, next_sync_sel;
    logic next_cal_bg, next_cal_ofs, next_overrange_enable;
    logic [OVR_THR_W-1:0] next_ovr_thr;
    logic [MODE_W-1:0] next_mode;
    logic [KM_W-1:0] next_km;
    logic [15:0] next_srst_cnt;
    logic next_ack;
    logic [31:0] next_readdata;
    logic trig_rise;
    ascs_link_e lstate, next_lstate;
    ascs_cal_e cstate, next_cstate;
    logic [15:0] cal_cnt, next_cal_cnt;
    logic sync_req;

    function automatic logic [31:0] stat_word(input ascs_link_e ls,
            input ascs_cal_e cs, input logic busy);
        stat_word = {26'h0000000, busy, cs, ls[3] ? 2'h3 :
            ls[2] ? 2'h2 : ls[1] ? 2'h1 : 2'h0};
    endfunction

    assign srst_busy = (srst_cnt != 16'h0000);
    assign sync_req = sync_sel ? !sync_ts_n : !sync_se_n;

    // Bus: one wait cycle per access, held off during soft reset
    always_comb begin
        next_ack = (read || write) && !ack && !srst_busy;
        next_link_en = link_en;
        next_cal_en = cal_en;
        next_trig = trig;
        next_sync_sel = sync_sel;
        next_cal_bg = cal_bg;
        next_cal_ofs = cal_ofs;
        next_overrange_enable = overrange_enable;
        next_ovr_thr = ovr_thr;
        next_mode = link_mode_select;
        next_km = multiframe_length_minus_one;
        next_srst_cnt = srst_busy ? srst_cnt - 16'h0001 : srst_cnt;
        next_readdata = readdata;
        trig_rise = 1'b0;
        if (next_ack && write) begin
            case (address)
                ADDR_CTRL: begin
                    if (writedata[CTRL_SRST]) begin
                        // Soft reset returns every setting to default
                        next_srst_cnt = SRST_WAIT[15:0];
                        next_link_en = CTRL_RESET[CTRL_LINK_EN];
                        next_cal_en = CTRL_RESET[CTRL_CAL_EN];
                        next_trig = 1'b0;
                        next_sync_sel = 1'b0;
                        next_cal_bg = 1'b0;
                        next_cal_ofs = 1'b0;
                        next_overrange_enable = 1'b0;
                        next_ovr_thr = '0;
                        next_mode = '0;
                        next_km = '0;
                    end else begin
                        next_link_en = writedata[CTRL_LINK_EN];
                        next_cal_en = writedata[CTRL_CAL_EN];
                        next_trig = writedata[CTRL_TRIG];
                        trig_rise = writedata[CTRL_TRIG] && !trig;
                        next_sync_sel = writedata[CTRL_SYNC_SEL];
                    end
                end
                // Link setting writes only take effect while the link is halted
                ADDR_MODE:
                    if (!link_en) next_mode = writedata[MODE_W-1:0];
                ADDR_KM:
                    if (!link_en) next_km = writedata[KM_W-1:0];
                ADDR_CALCFG: begin
                    if (!cal_en) begin
                        next_cal_bg = writedata[CAL_BG];
                        next_cal_ofs = writedata[CAL_OFS];
                    end
                end
                ADDR_OVR: begin
                    next_overrange_enable = writedata[OVERRANGE_ENABLE];
                    next_ovr_thr = writedata[OVR_THR_LSB +: OVR_THR_W];
                end
                default: ;
            endcase
        end
        if (next_ack && read) begin
            case (address)
                ADDR_CTRL: next_readdata = {27'h0, sync_sel, trig,
                    cal_en, link_en, srst_busy};
                ADDR_MODE: next_readdata = {27'h0, link_mode_select};
                ADDR_KM: next_readdata = {24'h0,
                    multiframe_length_minus_one};
                ADDR_CALCFG: next_readdata = {30'h0, cal_ofs, cal_bg};
                ADDR_OVR: next_readdata = {16'h0, ovr_thr, 7'h0,
                    overrange_enable};
                ADDR_STAT: next_readdata = stat_word(lstate, cstate,
                    cal_busy);
                default: next_readdata = BAD_ADDR_DATA;
            endcase
        end
    end

    // Link state machine
    always_comb begin
        next_lstate = lstate;
        case (lstate)
            ASCS_LNK_OFF: if (link_en) next_lstate = ASCS_LNK_WAIT;
            ASCS_LNK_WAIT: if (sync_req) next_lstate = ASCS_LNK_ALIGN;
            ASCS_LNK_ALIGN:
                if (!sync_req) next_lstate = ASCS_LNK_DATA;
            ASCS_LNK_DATA: if (sync_req) next_lstate = ASCS_LNK_ALIGN;
            default: next_lstate = ASCS_LNK_OFF;
        endcase
        if (!link_en) next_lstate = ASCS_LNK_OFF;
    end

    // Calibration state machine
    always_comb begin
        next_cstate = cstate;
        next_cal_cnt = cal_cnt;
        case (cstate)
            ASCS_CAL_OFF: if (cal_en) next_cstate = ASCS_CAL_IDLE;
            ASCS_CAL_IDLE: begin
                if (trig_rise) begin
                    next_cstate = ASCS_CAL_RUN;
                    next_cal_cnt = CAL_LEN[15:0];
                end
            end
            ASCS_CAL_RUN: begin
                next_cal_cnt = cal_cnt - 16'h0001;
                if (cal_cnt == 16'h0001) begin
                    // Background mode keeps tracking after first pass
                    if (cal_bg) next_cal_cnt = CAL_LEN[15:0];
                    else next_cstate = ASCS_CAL_IDLE;
                end
            end
            default: next_cstate = ASCS_CAL_OFF;
        endcase
        if (!cal_en) next_cstate = ASCS_CAL_OFF;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            readdata <= 32'h0;
            link_en <= CTRL_RESET[CTRL_LINK_EN];
            cal_en <= CTRL_RESET[CTRL_CAL_EN];
            trig <= 1'b0;
            sync_sel <= 1'b0;
            cal_bg <= 1'b0;
            cal_ofs <= 1'b0;
            overrange_enable <= 1'b0;
            ovr_thr <= '0;
            link_mode_select <= '0;
            multiframe_length_minus_one <= '0;
            srst_cnt <= 16'h0;
            lstate <= ASCS_LNK_OFF;
            cstate <= ASCS_CAL_OFF;
            cal_cnt <= 16'h0;
            waitrequest <= 1'b1;
            serial_link_enable <= 1'b0;
            link_running <= 1'b0;
            link_data_phase <= 1'b0;
            cal_running <= 1'b0;
            cal_busy <= 1'b0;
        end else begin
            ack <= next_ack;
            readdata <= next_readdata;
            link_en <= next_link_en;
            cal_en <= next_cal_en;
            trig <= next_trig;
            sync_sel <= next_sync_sel;
            cal_bg <= next_cal_bg;
            cal_ofs <= next_cal_ofs;
            overrange_enable <= next_overrange_enable;
            ovr_thr <= next_ovr_thr;
            link_mode_select <= next_mode;
            multiframe_length_minus_one <= next_km;
            srst_cnt <= next_srst_cnt;
            lstate <= next_lstate;
            cstate <= next_cstate;
            cal_cnt <= next_cal_cnt;
            waitrequest <= !next_ack;
            serial_link_enable <= next_link_en;
            link_running <= (next_lstate != ASCS_LNK_OFF);
            link_data_phase <= (next_lstate == ASCS_LNK_DATA);
            cal_running <= (next_cstate != ASCS_CAL_OFF);
            cal_busy <= (next_cstate == ASCS_CAL_RUN);
        end
    end
endmodule
`default_nettype wire

// ### design/ascs_pkg.sv
// Constants for the startup configuration sequencer
package ascs_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SRST_WAIT_NS = 1000;
    localparam int unsigned SRST_CYCLES =
        (SRST_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_MODE = 6'h04;
    localparam logic [5:0] ADDR_KM = 6'h08;
    localparam logic [5:0] ADDR_CALCFG = 6'h0c;
    localparam logic [5:0] ADDR_OVR = 6'h10;
    localparam logic [5:0] ADDR_STAT = 6'h14;
    // Control bits
    localparam int CTRL_SRST = 0;
    localparam int CTRL_LINK_EN = 1;
    localparam int CTRL_CAL_EN = 2;
    localparam int CTRL_TRIG = 3;
    localparam int CTRL_SYNC_SEL = 4;
    // Calibration configuration bits
    localparam int CAL_BG = 0;
    localparam int CAL_OFS = 1;
    // Overrange register
    localparam int OVERRANGE_ENABLE = 0;
    localparam int OVR_THR_LSB = 8;
    localparam int OVR_THR_W = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_0bad;
    localparam int MODE_W = 5;
    localparam int KM_W = 8;
    localparam int CAL_CYCLES = 64;
    typedef enum logic [3:0] {
        ASCS_LNK_OFF = 4'b0001,
        ASCS_LNK_WAIT = 4'b0010,
        ASCS_LNK_ALIGN = 4'b0100,
        ASCS_LNK_DATA = 4'b1000
    } ascs_link_e;
    typedef enum logic [2:0] {
        ASCS_CAL_OFF = 3'b001,
        ASCS_CAL_IDLE = 3'b010,
        ASCS_CAL_RUN = 3'b100
    } ascs_cal_e;
endpackage

// ### design/ascs_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ascs_sync2 (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic meta;
    logic next_meta;
    logic next_dout;
    always_comb begin
        next_meta = din;
        next_dout = meta;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // Idle high like the active-low pins, no false request
            meta <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// ### testbench/ascs_top_asserts.sv
// Concurrent checks on the sequencer top ports
`timescale 1ns/1ns
`default_nettype none
module ascs_chk
    import ascs_pkg::*;
#(
    parameter int unsigned SRST_WAIT = SRST_CYCLES,
    parameter int unsigned CAL_LEN = CAL_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic serial_link_enable,
    input wire logic link_running,
    input wire logic link_data_phase,
    input wire logic cal_running,
    input wire logic cal_busy,
    input wire logic [MODE_W-1:0] link_mode_select,
    input wire logic [KM_W-1:0] multiframe_length_minus_one
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Bound covers the longest soft reset stall
    a_bus_answer: assert property (
        (read || write) && waitrequest |-> ##[1:12] !waitrequest)
        else $error("bus answer late");
    a_answer_pulse: assert property (
        !waitrequest |=> waitrequest)
        else $error("answer held");
    a_link_halt: assert property (
        !serial_link_enable [*2] |-> !link_running)
        else $error("link not halted");
    a_cal_halt: assert property (
        !cal_running |-> !cal_busy)
        else $error("cal busy while halted");
    // Sync may already be asserted, so data can follow two cycles on
    a_link_restart: assert property (
        $rose(link_running) |-> !link_data_phase [*2])
        else $error("data phase too soon");
    a_data_running: assert property (
        link_data_phase |-> link_running)
        else $error("data phase while halted");
    a_mode_lock: assert property (
        write && !waitrequest && address == ADDR_MODE &&
        serial_link_enable |-> $stable(link_mode_select))
        else $error("mode changed while running");
    a_km_lock: assert property (
        write && !waitrequest && address == ADDR_KM &&
        serial_link_enable |-> $stable(multiframe_length_minus_one))
        else $error("length changed while running");
    a_cal_span: assert property (
        $rose(cal_busy) |-> cal_busy [*3])
        else $error("calibration cut short");
    c_data: cover property ($rose(link_data_phase));
    c_cal: cover property ($rose(cal_busy));
    c_read: cover property (read && !waitrequest);
endmodule
bind ascs_top ascs_chk #(
    .SRST_WAIT(SRST_WAIT),
    .CAL_LEN(CAL_LEN)
) u_chk (
    .mclk(mclk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .serial_link_enable(serial_link_enable),
    .link_running(link_running),
    .link_data_phase(link_data_phase),
    .cal_running(cal_running),
    .cal_busy(cal_busy),
    .link_mode_select(link_mode_select),
    .multiframe_length_minus_one(multiframe_length_minus_one)
);
`default_nettype wire

// ### testbench/ascs_sync_rx.sv
// Link receiver model raising a sync request after each link start
`timescale 1ns/1ns
`default_nettype none
module ascs_sync_rx #(
    parameter int REQ_LEN = 6
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic link_running,
    input wire logic use_ts,
    output logic single_ended_sync_input_n,
    output logic timestamp_sync_n
);
    logic run_q;
    int cnt;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
            cnt <= 0;
        end else begin
            run_q <= link_running;
            if (link_running && !run_q) begin
                cnt <= REQ_LEN;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    // Unused pin idles high as its pull-up would leave it
    assign single_ended_sync_input_n = !(cnt > 0 && !use_ts);
    assign timestamp_sync_n = !(cnt > 0 && use_ts);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the startup sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    failures++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
    import ascs_pkg::*;
    typedef struct {
        logic [5:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } ascs_row_s;
    logic mclk = 0, rstn = 0, read = 0, write = 0, use_ts = 0;
    logic [5:0] address = 0;
    logic [31:0] writedata = 0, readdata, q;
    logic waitrequest, se_n, ts_n, l_en, l_run, l_data, c_run, c_busy;
    logic [4:0] mode;
    logic [7:0] km;
    int failures = 0, n_checks = 0;
    time t0;
    // Host steps in order, then an unmapped place
    ascs_row_s rows[9] = '{'{6'h00, 32'h0, 32'h0}, '{6'h04, 32'h13, 32'h13},
        '{6'h08, 32'h1f, 32'h1f}, '{6'h00, 32'h10, 32'h10},
        '{6'h0c, 32'h2, 32'h2}, '{6'h00, 32'h14, 32'h14},
        '{6'h10, 32'h5a01, 32'h5a01}, '{6'h00, 32'h16, 32'h16},
        '{6'h3c, 32'h1, 32'hdead_0bad}};
    ascs_top #(.CAL_LEN(4)) dut (.mclk(mclk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .single_ended_sync_input_n(se_n), .timestamp_sync_n(ts_n),
        .serial_link_enable(l_en), .link_running(l_run),
        .link_data_phase(l_data), .cal_running(c_run), .cal_busy(c_busy),
        .link_mode_select(mode), .multiframe_length_minus_one(km));
    ascs_sync_rx rx (.mclk(mclk), .rstn(rstn), .link_running(l_run),
        .use_ts(use_ts), .single_ended_sync_input_n(se_n),
        .timestamp_sync_n(ts_n));
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic xfer(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= d;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h1);
        t0 = $time;
        xfer(1'b0, ADDR_MODE, 32'h0);
        `CHK("srst stall", 1'b1, ($time - t0) >= 1000)
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d);
            xfer(1'b0, rows[i].a, 32'h0);
            `CHK("row read", rows[i].e, q)
        end
        // Receiver still on the unselected pin
        repeat (20) @(negedge mclk);
        `CHK("no data", 1'b0, l_data)
        `CHK("mode km", {5'h13, 8'h1f}, {mode, km})
        `CHK("running", 3'b111, {l_en, l_run, c_run})
        xfer(1'b1, ADDR_CALCFG, 32'h1);
        xfer(1'b0, ADDR_CALCFG, 32'h0);
        `CHK("calcfg locked", 32'h2, q)
        xfer(1'b1, ADDR_MODE, 32'h1);
        `CHK("mode locked", 5'h13, mode)
        xfer(1'b1, ADDR_KM, 32'h1);
        `CHK("km locked", 8'h1f, km)
        use_ts <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h14);
        repeat (2) @(negedge mclk);
        `CHK("link halted", 1'b0, l_run)
        xfer(1'b1, ADDR_CTRL, 32'h16);
        repeat (20) @(negedge mclk);
        `CHK("data phase", 1'b1, l_data)
        // Data phase code 3, calibration idle, not busy
        xfer(1'b0, ADDR_STAT, 32'h0);
        `CHK("status", 32'h0000_000b, q)
        xfer(1'b1, ADDR_CTRL, 32'h1e);
        repeat (2) @(negedge mclk);
        `CHK("cal start", 1'b1, c_busy)
        repeat (8) @(negedge mclk);
        `CHK("cal done", 1'b0, c_busy)
        // Trigger left high must not start another run
        xfer(1'b1, ADDR_CTRL, 32'h1e);
        repeat (2) @(negedge mclk);
        `CHK("no retrigger", 1'b0, c_busy)
        xfer(1'b1, ADDR_CTRL, 32'h1a);
        repeat (2) @(negedge mclk);
        `CHK("cal halted", 1'b0, c_run)
        xfer(1'b1, ADDR_CTRL, 32'h16);
        repeat (2) @(negedge mclk);
        `CHK("cal resumed", 1'b1, c_run)
        // Mid-run reset
        @(posedge mclk);
        rstn <= 1'b0;
        @(negedge mclk);
        `CHK("in reset", 3'b100, {waitrequest, l_en, c_run})
        @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(negedge mclk);
        `CHK("after reset", 3'b111, {l_en, l_run, c_run})
        xfer(1'b0, ADDR_MODE, 32'h0);
        `CHK("reset mode", 32'h0, q)
        final_report();
    end
endmodule
`default_nettype wire
